// *** rtl/flash_host_pkg.sv ***
// shared constants, types and register map of the flash host controller
package flash_host_pkg;
  // device geometry
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int BYTES = 1048576;
  localparam int WORDS = 524288;
  // command cycle codes (word addresses)
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002aa;
  localparam logic [7:0] UNLOCK1_DATA = 8'haa;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  // status bit positions and the byte-mode address bit
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERASE_TOGGLE_BIT = 2;
  localparam int BYTE_ADDR_BIT = 15;
  // bus timing (ns) and derived cycle counts at 100 MHz
  localparam int CLK_NS = 10;
  localparam int ACCESS_NS = 70;
  localparam int WE_PULSE_NS = 35;
  localparam int RESET_PULSE_NS = 500;
  localparam logic [7:0] ACCESS_CYC = 8'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WE_CYC = 8'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RESET_CYC = 8'((RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
  // software register offsets
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h1;
  localparam logic [3:0] REG_CMD = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h5;
  // command codes written to REG_CMD
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_READ = 4'h1, OP_PROGRAM = 4'h2, OP_SECTOR_ERASE = 4'h3,
    OP_CHIP_ERASE = 4'h4, OP_BYPASS_ENTER = 4'h5, OP_BYPASS_EXIT = 4'h6,
    OP_SUSPEND = 4'h7, OP_RESUME = 4'h8, OP_RESET = 4'h9, OP_HW_RESET = 4'ha
  } op_t;
  // one bus cycle toward the flash
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_req_t;
  // status seen by software
  typedef struct packed {
    logic timeout;
    logic fail;
    logic toggling;
    logic busy;
  } stat_t;
endpackage : flash_host_pkg

// *** rtl/flash_bus_cycle.sv ***
// one timed asynchronous read or write cycle on the flash pins
`timescale 1ns/1ns
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // request
  input wire logic start_i,
  input bus_req_t req_i,
  input wire logic byte_mode_i,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  // pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic [DATA_W-1:0] dq_oe_o,
  input wire logic [DATA_W-1:0] dq_i
);
  typedef enum logic [1:0] {CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_STROBE = 2'b10, CY_HOLD = 2'b11} cy_t;
  cy_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  bus_req_t req_r, req_nxt;
  logic [DATA_W-1:0] rd_r, rd_nxt;
  logic done_r, done_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    req_nxt = req_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    unique case (st_r)
      CY_IDLE: begin
        if (start_i) begin
          req_nxt = req_i;
          st_nxt = CY_SETUP;
        end
      end
      CY_SETUP: begin
        cnt_nxt = req_r.write ? WE_CYC : ACCESS_CYC;
        st_nxt = CY_STROBE;
      end
      CY_STROBE: begin
        if (cnt_r <= 8'h01) begin
          // byte mode keeps only the low lane
          rd_nxt = byte_mode_i ? {8'h00, dq_i[7:0]} : dq_i; // RULE1
          st_nxt = CY_HOLD;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      CY_HOLD: begin
        done_nxt = 1'b1;
        st_nxt = CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r <= CY_IDLE;
      cnt_r <= 8'h00;
      req_r <= '0;
      rd_r <= '0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and data held across setup, strobe and hold; device latches on we rise
  assign done_o = done_r;
  assign rdata_o = rd_r;
  assign ce_n_o = (st_r == CY_IDLE);
  assign oe_n_o = !(st_r == CY_STROBE && !req_r.write);
  assign we_n_o = !(st_r == CY_STROBE && req_r.write); // RULE5
  // in byte mode dq15 carries bit 15 of the request data (zero on reads), driven as an output
  assign addr_o = req_r.addr;
  assign dq_o = byte_mode_i ? {req_r.data[BYTE_ADDR_BIT], 7'h00, req_r.data[7:0]} : req_r.data; // RULE2
  assign dq_oe_o = (st_r == CY_IDLE) ? '0 :
                   byte_mode_i ? {1'b1, 7'h00, {8{req_r.write}}} : {DATA_W{req_r.write}}; // RULE2
endmodule : flash_bus_cycle

// *** rtl/flash_host.sv ***
// host controller that issues command sequences to the boot-sector flash
`timescale 1ns/1ns
// Notes on behaviour
// RULE1 - array of 1M bytes or 512K words
// RULE2 - byte mode: dq15 becomes lowest address; the host drives it from data bit 15, zero on reads
// RULE3 - bit 6 toggles while busy or suspended
// RULE4 - bit 2 toggles in sectors chosen for erase
// RULE5 - commands are plain write cycles, latched
// RULE6 - program sequence starts self-timed program
// RULE7 - erase sequence starts self-timed erase
// RULE8 - bypass program needs two writes, not four
// RULE9 - completion seen on ready pin or polling
// RULE10 - after completion device reads array again
// RULE11 - reset pin aborts, returns to array read
// RULE12 - erase may be suspended, then resumed; host sends suspend only when idle, never during an erase
// RULE13 - protected sectors refuse program and erase
// RULE14 - temporary unprotect allows protected sector changes
// RULE15 - sector map 16K, 2x8K, 32K, 15x64K
// RULE16 - boot sectors at top or bottom
// RULE17 - shipped erased; sectors independent
// RULE18 - stable addresses put device asleep
// RULE19 - command register has no array address
// RULE20 - erased reads ones; program clears bits
module flash_host
  import flash_host_pkg::*;
#(
  parameter int POLL_LIMIT = 100000
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // software port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // flash pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic reset_n_o,
  output logic byte_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic [DATA_W-1:0] dq_oe_o,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic ready_busy_out_i
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_SEQ = 3'b001, H_WAIT = 3'b010, H_POLL = 3'b011, H_RST = 3'b100
  } host_t;

  host_t st_r, st_nxt;
  logic [ADDR_W-1:0] taddr_r, taddr_nxt;
  logic [DATA_W-1:0] tdata_r, tdata_nxt;
  op_t op_r, op_nxt;
  logic [2:0] step_r, step_nxt;
  logic [2:0] nsteps_r, nsteps_nxt;
  logic bypass_r, bypass_nxt;
  logic byte_mode_r, byte_mode_nxt;
  logic use_pin_r, use_pin_nxt;
  stat_t stat_r, stat_nxt;
  logic [DATA_W-1:0] rdreg_r, rdreg_nxt;
  logic [DATA_W-1:0] prev_r, prev_nxt;
  logic [31:0] pcnt_r, pcnt_nxt;
  logic [7:0] rcnt_r, rcnt_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic cyc_start;
  bus_req_t cyc_req;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // n-th write of a command sequence; unlock cycles for bypass program are skipped by the caller
  function automatic bus_req_t seq_word(op_t op, logic [2:0] step, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    bus_req_t r;
    r.write = 1'b1;
    r.addr = UNLOCK1_ADDR;
    r.data = {8'h00, UNLOCK1_DATA};
    unique case (op)
      OP_PROGRAM: begin
        if (step == 3'd1) r = '{1'b1, UNLOCK2_ADDR, {8'h00, UNLOCK2_DATA}};
        if (step == 3'd2) r.data = {8'h00, CMD_PROGRAM};
        if (step == 3'd3) r = '{1'b1, a, d}; // RULE6
      end
      OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
        if (step == 3'd1 || step == 3'd4) r = '{1'b1, UNLOCK2_ADDR, {8'h00, UNLOCK2_DATA}};
        if (step == 3'd2) r.data = {8'h00, CMD_ERASE};
        if (step == 3'd5) r = (op == OP_CHIP_ERASE) ? '{1'b1, UNLOCK1_ADDR, {8'h00, CMD_CHIP_ERASE}}
                                                     : '{1'b1, a, {8'h00, CMD_SECTOR_ERASE}}; // RULE7
      end
      OP_BYPASS_ENTER: begin
        if (step == 3'd1) r = '{1'b1, UNLOCK2_ADDR, {8'h00, UNLOCK2_DATA}};
        if (step == 3'd2) r.data = {8'h00, CMD_BYPASS};
      end
      OP_BYPASS_EXIT: begin
        r = '{1'b1, a, {8'h00, (step == 3'd0) ? CMD_BYPASS_EXIT1 : CMD_BYPASS_EXIT2}};
      end
      default: r = '{1'b1, a, {8'h00, CMD_RESET}};
    endcase
    return r;
  endfunction : seq_word

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    taddr_nxt = taddr_r;
    tdata_nxt = tdata_r;
    op_nxt = op_r;
    step_nxt = step_r;
    nsteps_nxt = nsteps_r;
    bypass_nxt = bypass_r;
    byte_mode_nxt = byte_mode_r;
    use_pin_nxt = use_pin_r;
    stat_nxt = stat_r;
    rdreg_nxt = rdreg_r;
    prev_nxt = prev_r;
    pcnt_nxt = pcnt_r;
    rcnt_nxt = rcnt_r;
    rdata_nxt = 32'h0000_0000;
    cyc_start = 1'b0;
    cyc_req = seq_word(op_r, step_r, taddr_r, tdata_r);
    if (bypass_r && op_r == OP_PROGRAM) begin
      cyc_req = (step_r == 3'd0) ? '{1'b1, UNLOCK1_ADDR, {8'h00, CMD_PROGRAM}} : '{1'b1, taddr_r, tdata_r}; // RULE8
    end
    if (wr_i) begin
      unique case (addr_i)
        REG_ADDR: taddr_nxt = wdata_i[ADDR_W-1:0];
        REG_DATA: tdata_nxt = wdata_i[DATA_W-1:0];
        REG_CTRL: begin
          byte_mode_nxt = wdata_i[0]; // RULE2
          use_pin_nxt = wdata_i[1];
        end
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        REG_ADDR: rdata_nxt = {13'h0000, taddr_r};
        REG_DATA: rdata_nxt = {16'h0000, tdata_r};
        REG_STATUS: rdata_nxt = {27'h0000000, bypass_r, stat_r};
        REG_RDATA: rdata_nxt = {16'h0000, rdreg_r};
        REG_CTRL: rdata_nxt = {30'h00000000, use_pin_r, byte_mode_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    unique case (st_r)
      H_IDLE: begin
        if (wr_i && addr_i == REG_CMD && op_t'(wdata_i[3:0]) != OP_NONE) begin
          op_nxt = op_t'(wdata_i[3:0]);
          step_nxt = 3'd0;
          stat_nxt = '0;
          st_nxt = H_SEQ;
          unique case (op_t'(wdata_i[3:0]))
            OP_READ: nsteps_nxt = 3'd0;
            OP_PROGRAM: nsteps_nxt = bypass_r ? 3'd1 : 3'd3; // RULE8
            OP_SECTOR_ERASE, OP_CHIP_ERASE: nsteps_nxt = 3'd5;
            OP_BYPASS_ENTER: nsteps_nxt = 3'd2;
            OP_BYPASS_EXIT: nsteps_nxt = 3'd1;
            default: nsteps_nxt = 3'd0;
          endcase
          if (op_t'(wdata_i[3:0]) == OP_HW_RESET) begin
            rcnt_nxt = RESET_CYC;
            // busy covers the pulse so no command lands inside it
            stat_nxt.busy = 1'b1; // RULE11
            st_nxt = H_RST;
          end
        end
      end
      H_SEQ: begin
        cyc_start = 1'b1;
        if (op_r == OP_READ) cyc_req = '{1'b0, taddr_r, 16'h0000};
        if (op_r == OP_SUSPEND) cyc_req = '{1'b1, taddr_r, {8'h00, CMD_SUSPEND}}; // RULE12
        if (op_r == OP_RESUME) cyc_req = '{1'b1, taddr_r, {8'h00, CMD_RESUME}}; // RULE12
        stat_nxt.busy = 1'b1;
        st_nxt = H_WAIT;
      end
      H_WAIT: begin
        if (cyc_done) begin
          if (op_r == OP_READ) begin
            rdreg_nxt = cyc_rdata;
            stat_nxt.busy = 1'b0;
            st_nxt = H_IDLE;
          end else if (step_r < nsteps_r) begin
            step_nxt = step_r + 3'd1;
            st_nxt = H_SEQ;
          end else if (op_r == OP_PROGRAM || op_r == OP_SECTOR_ERASE || op_r == OP_CHIP_ERASE) begin
            // first status read seeds the toggle comparison
            op_nxt = OP_READ;
            pcnt_nxt = 32'h0000_0000;
            prev_nxt = '0;
            step_nxt = 3'd7;
            st_nxt = H_POLL;
          end else begin
            bypass_nxt = (op_r == OP_BYPASS_ENTER) ? 1'b1 : (op_r == OP_BYPASS_EXIT || op_r == OP_RESET) ? 1'b0 : bypass_r;
            stat_nxt.busy = 1'b0;
            st_nxt = H_IDLE;
          end
        end else if (st_r == H_POLL) begin
          st_nxt = H_POLL;
        end
      end
      H_POLL: begin
        // status reads while the embedded algorithm runs
        cyc_start = (step_r == 3'd7);
        cyc_req = '{1'b0, taddr_r, 16'h0000};
        if (cyc_start) step_nxt = 3'd6;
        if (cyc_done) begin
          prev_nxt = cyc_rdata;
          pcnt_nxt = pcnt_r + 32'h0000_0001;
          stat_nxt.toggling = (cyc_rdata[ERASE_TOGGLE_BIT] != prev_r[ERASE_TOGGLE_BIT]); // RULE4
          step_nxt = 3'd7;
          if (pcnt_r != 32'h0000_0000 && (use_pin_r ? ready_busy_out_i
              : cyc_rdata[TOGGLE_BIT] == prev_r[TOGGLE_BIT])) begin // RULE3 RULE9
            // done: device is back in array read; when polling, recheck data for failure
            rdreg_nxt = cyc_rdata; // RULE10
            stat_nxt.fail = cyc_rdata[POLL_BIT] != tdata_r[POLL_BIT] && tdata_r != '1 && !use_pin_r; // RULE13
            stat_nxt.busy = 1'b0;
            st_nxt = H_IDLE;
          end else if (pcnt_r >= 32'(POLL_LIMIT)) begin
            // busy stays up until the reset pulse ends
            stat_nxt.timeout = 1'b1;
            rcnt_nxt = RESET_CYC;
            st_nxt = H_RST;
          end
        end
      end
      H_RST: begin
        // pulse the reset pin to abort and return to array read
        if (rcnt_r <= 8'h01) begin
          bypass_nxt = 1'b0;
          stat_nxt.busy = 1'b0;
          st_nxt = H_IDLE;
        end else begin
          rcnt_nxt = rcnt_r - 8'h01; // RULE11
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r <= H_IDLE;
      taddr_r <= '0;
      tdata_r <= '0;
      op_r <= OP_NONE;
      step_r <= 3'd0;
      nsteps_r <= 3'd0;
      bypass_r <= 1'b0;
      byte_mode_r <= 1'b0;
      use_pin_r <= 1'b0;
      stat_r <= '0;
      rdreg_r <= '0;
      prev_r <= '0;
      pcnt_r <= 32'h0000_0000;
      rcnt_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      taddr_r <= taddr_nxt;
      tdata_r <= tdata_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      nsteps_r <= nsteps_nxt;
      bypass_r <= bypass_nxt;
      byte_mode_r <= byte_mode_nxt;
      use_pin_r <= use_pin_nxt;
      stat_r <= stat_nxt;
      rdreg_r <= rdreg_nxt;
      prev_r <= prev_nxt;
      pcnt_r <= pcnt_nxt;
      rcnt_r <= rcnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  flash_bus_cycle u_cycle (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(cyc_start),
    .req_i(cyc_req),
    .byte_mode_i(byte_mode_r),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe_o),
    .dq_i(dq_i)
  );

  assign rdata_o = rdata_r;
  assign reset_n_o = !(st_r == H_RST); // RULE11
  assign byte_n_o = !byte_mode_r; // RULE2
endmodule : flash_host

// *** sim/flash_model.sv ***
// behavioural flash device answering the host pins
`timescale 1ns/1ns
module flash_model
  import flash_host_pkg::*;
#(
  parameter bit TOP_BOOT = 1'b0,
  parameter int SLEEP_CYC = 20
)(
  // pins from the host
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic byte_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  // pins to the host
  output logic [DATA_W-1:0] dq_o,
  output logic ready_busy_out_o
);
  // small array: four words per 4k-word block, enough to tell sectors apart
  logic [DATA_W-1:0] mem [0:511];
  logic [DATA_W-1:0] q = 16'h0000, td = 16'h0000;
  logic [ADDR_W-1:0] ta = 19'h00000, last_a = 19'h00000;
  logic byp = 0, pend = 0, tog = 0, unprot = 0, asleep = 0;
  logic [18:0] prot = 19'h00000;
  int step = 0, kind = 0, busy = 0, s = 0, still = 0;
  // sector number: 8k, 4k, 4k, 16k words in the boot block, then 32k-word sectors
  function automatic int sec(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] b;
    b = TOP_BOOT ? ~a : a;
    if (b[18:15] != 4'h0) return int'(b[18:15]) + 3;
    if (b[14]) return 3;
    return b[13] ? (b[12] ? 2 : 1) : 0;
  endfunction : sec
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign ready_busy_out_o = (busy == 0);
  // released lines show the inverse so a stale value never passes
  assign dq_o = (!ce_n_i && !oe_n_i && reset_n_i) ? q : ~q;
  always @(posedge we_n_i) if (!ce_n_i && reset_n_i && busy == 0) begin
    if (pend) begin
      pend = 0;
      ta = addr_i;
      td = dq_i;
      kind = 1;
      busy = (prot[sec(addr_i)] && !unprot) ? 8 : 40;
    end else if (dq_i[7:0] == CMD_RESET) step = 0;
    else if (byp) begin
      pend = (dq_i[7:0] == CMD_PROGRAM);
      if (dq_i[7:0] == CMD_BYPASS_EXIT2) byp = 0;
    end else case (step)
      0, 3: step = (dq_i[7:0] == UNLOCK1_DATA && addr_i == UNLOCK1_ADDR) ? step + 1 : 0;
      1, 4: step = (dq_i[7:0] == UNLOCK2_DATA && addr_i == UNLOCK2_ADDR) ? step + 1 : 0;
      2: begin
        step = (dq_i[7:0] == CMD_ERASE) ? 3 : 0;
        pend = (dq_i[7:0] == CMD_PROGRAM);
        byp = (dq_i[7:0] == CMD_BYPASS);
      end
      default: begin
        step = 0;
        ta = addr_i;
        kind = (dq_i[7:0] == CMD_SECTOR_ERASE) ? 2 : 3;
        busy = (kind == 2) ? 100 : 20000;
      end
    endcase
  end
  always @(posedge clk_i) begin
    still = (addr_i != last_a) ? 0 : (still < SLEEP_CYC) ? still + 1 : still;
    last_a = addr_i;
    asleep = (still >= SLEEP_CYC);
    if (!reset_n_i) begin
      busy = 0;
      step = 0;
      byp = 0;
      pend = 0;
    end else if (busy == 1) begin
      if (kind == 1) begin
        if (!prot[sec(ta)] || unprot) mem[{ta[18:12], ta[1:0]}] = mem[{ta[18:12], ta[1:0]}] & td;
      end else foreach (mem[i]) begin
        s = sec({7'(i >> 2), 10'h000, 2'(i)});
        if ((kind == 3 || s == sec(ta)) && (!prot[s] || unprot)) mem[i] = 16'hffff;
      end
      busy = 0;
    end else if (busy > 0) busy = busy - 1;
  end
  always @(negedge oe_n_i) if (!ce_n_i) begin
    if (busy > 0) begin
      tog = !tog;
      q = 16'h0000;
      q[POLL_BIT] = (kind == 1) ? !td[7] : 1'b0;
      q[TOGGLE_BIT] = tog;
      q[ERASE_TOGGLE_BIT] = (kind != 1) && tog;
    end else q = mem[{addr_i[18:12], addr_i[1:0]}];
    if (!byte_n_i) q = {8'h00, dq_i[15] ? q[15:8] : q[7:0]};
  end
endmodule : flash_model

// *** sim/flash_host_asserts.sv ***
// pin protocol checker for the flash host controller
`timescale 1ns/1ns
module flash_host_asserts
  import flash_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic reset_n_o,
  input wire logic byte_n_o,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic [DATA_W-1:0] dq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_strobe_excl: assert property (oe_n_o || we_n_o) else $error("oe and we low together");
  a_we_under_ce: assert property (!we_n_o |-> !ce_n_o) else $error("we low without ce");
  a_we_width: assert property ($fell(we_n_o) |-> !we_n_o [*4] ##1 we_n_o) else $error("we width");
  a_oe_width: assert property ($fell(oe_n_o) |-> !oe_n_o [*7] ##1 oe_n_o) else $error("oe width");
  a_write_driven: assert property (!we_n_o |-> dq_oe_o[7:0] == 8'hff) else $error("write undriven");
  a_read_released: assert property (!oe_n_o |-> dq_oe_o[14:0] == 15'h0000) else $error("read contention");
  a_byte_upper: assert property (!byte_n_o |-> dq_oe_o[14:8] == 7'h00) else $error("upper lines driven");
  a_addr_held: assert property (!we_n_o && !$past(we_n_o) |-> $stable(addr_o)) else $error("addr moved");
  a_reset_pulse: assert property ($fell(reset_n_o) |-> ##49 !reset_n_o ##1 reset_n_o) else $error("pulse len");
  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata not quiet");
  c_write: cover property ($fell(we_n_o));
  c_reset: cover property ($fell(reset_n_o));
  c_byte_read: cover property (!byte_n_o && !oe_n_o);
endmodule : flash_host_asserts

// *** sim/flash_host_tb_top.sv ***
// self-checking bench for the flash host controller
`timescale 1ns/1ns
module flash_host_tb_top;
  import flash_host_pkg::*;
  typedef struct {op_t op; logic [18:0] a; logic [15:0] d; logic [18:0] rb; logic [15:0] x; int w;} row_t;
  logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, ce_n_o, oe_n_o, we_n_o, reset_n_o, byte_n_o, rb_w;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, v;
  logic [ADDR_W-1:0] addr_o;
  logic [DATA_W-1:0] dq_o, dq_oe_o, mq, dq_w;
  int error_cnt = 0, tests_run = 0, wes = 0, rlo = 0;
  row_t rows [14] = '{
    '{OP_PROGRAM, 19'h00010, 16'h1234, 19'h00010, 16'h1234, 4},
    '{OP_PROGRAM, 19'h08010, 16'h5678, 19'h08010, 16'h5678, 4},
    '{OP_PROGRAM, 19'h00010, 16'hff0f, 19'h00010, 16'h1204, 4},
    '{OP_PROGRAM, 19'h04010, 16'h0f0f, 19'h04010, 16'h0f0f, 4},
    '{OP_SECTOR_ERASE, 19'h00010, 16'h0000, 19'h00010, 16'hffff, 6},
    '{OP_READ, 19'h04010, 16'h0000, 19'h04010, 16'h0f0f, 0},
    '{OP_READ, 19'h08010, 16'h0000, 19'h08010, 16'h5678, 0},
    '{OP_BYPASS_ENTER, 19'h00000, 16'h0000, 19'h00010, 16'hffff, 3},
    '{OP_PROGRAM, 19'h00011, 16'ha5a5, 19'h00011, 16'ha5a5, 2},
    '{OP_BYPASS_EXIT, 19'h00000, 16'h0000, 19'h00011, 16'ha5a5, 2},
    '{OP_RESET, 19'h00000, 16'h0000, 19'h00011, 16'ha5a5, 1},
    '{OP_SUSPEND, 19'h00000, 16'h0000, 19'h00011, 16'ha5a5, 1},
    '{OP_RESUME, 19'h00000, 16'h0000, 19'h00011, 16'ha5a5, 1},
    '{OP_HW_RESET, 19'h00000, 16'h0000, 19'h00011, 16'ha5a5, 0}};
  // host and device share the data lines per bit
  assign dq_w = (dq_oe_o & dq_o) | (~dq_oe_o & mq);
  flash_host #(.POLL_LIMIT(20)) dut (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ce_n_o,
    .oe_n_o, .we_n_o, .reset_n_o, .byte_n_o, .addr_o, .dq_o, .dq_oe_o, .dq_i(dq_w), .ready_busy_out_i(rb_w));
  flash_model mdl (.clk_i, .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .reset_n_i(reset_n_o),
    .byte_n_i(byte_n_o), .addr_i(addr_o), .dq_i(dq_w), .dq_o(mq), .ready_busy_out_o(rb_w));
  initial forever #5 clk_i = ~clk_i;
  always @(negedge we_n_o) wes++;
  always @(posedge clk_i) if (reset_n_o === 1'b0) rlo++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  // bounded wait: a stuck busy flag ends here rather than hanging
  task automatic run(input op_t op, input logic [18:0] a, input logic [15:0] d);
    int n;
    n = 0;
    wr(REG_ADDR, {13'h0, a});
    wr(REG_DATA, {16'h0, d});
    wr(REG_CMD, {28'h0, op});
    rd(REG_STATUS);
    while (v[0] !== 1'b0 && n < 1000) begin
      rd(REG_STATUS);
      n++;
    end
    if (n >= 1000) begin
      error_cnt++;
      test_done();
    end
  endtask : run
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    #300000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    chk({11'h0, ce_n_o, oe_n_o, we_n_o, reset_n_o, byte_n_o, dq_oe_o}, {11'h0, 5'h1f, 16'h0});
    nrst_i <= 1'b1;
    foreach (rows[i]) begin
      wes = 0;
      run(rows[i].op, rows[i].a, rows[i].d);
      chk(wes, rows[i].w);
      run(OP_READ, rows[i].rb, 16'h0);
      rd(REG_RDATA);
      chk(v, {16'h0, rows[i].x});
      $display("row %0d done", i);
    end
    rd(4'hf);
    chk(v, 32'h0);
    wr(4'he, 32'hffff);
    $display("unmapped done");
    rlo = 0;
    run(OP_CHIP_ERASE, 19'h0, 16'h0);
    chk({31'h0, v[3]}, 32'h1);
    chk(rlo, {24'h0, RESET_CYC});
    run(OP_READ, 19'h00011, 16'h0);
    rd(REG_RDATA);
    chk(v, 32'ha5a5);
    $display("timeout abort done");
    wr(REG_CTRL, 32'h1);
    run(OP_READ, 19'h00011, 16'h0);
    chk({31'h0, byte_n_o}, 32'h0);
    rd(REG_RDATA);
    chk({24'h0, v[7:0]}, 32'ha5);
    wr(REG_CTRL, 32'h0);
    $display("byte mode done");
    wr(REG_CTRL, 32'h2);
    run(OP_PROGRAM, 19'h08011, 16'h3c3c);
    run(OP_READ, 19'h08011, 16'h0);
    rd(REG_RDATA);
    chk(v, 32'h3c3c);
    wr(REG_CTRL, 32'h0);
    $display("ready pin done");
    mdl.prot[0] = 1'b1;
    run(OP_PROGRAM, 19'h00012, 16'h0000);
    chk({31'h0, v[2]}, 32'h1);
    run(OP_READ, 19'h00012, 16'h0);
    rd(REG_RDATA);
    chk(v, 32'hffff);
    mdl.unprot = 1'b1;
    run(OP_PROGRAM, 19'h00012, 16'h0000);
    chk({31'h0, v[2]}, 32'h0);
    run(OP_READ, 19'h00012, 16'h0);
    rd(REG_RDATA);
    chk(v, 32'h0);
    $display("protection done");
    repeat (25) @(posedge clk_i);
    chk({31'h0, mdl.asleep}, 32'h1);
    $display("sleep done");
    wr(REG_ADDR, 32'h13);
    wr(REG_CMD, {28'h0, OP_PROGRAM});
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk({28'h0, ce_n_o, we_n_o, reset_n_o, dq_oe_o[0]}, 32'he);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    run(OP_READ, 19'h00013, 16'h0);
    rd(REG_RDATA);
    chk(v, 32'hffff);
    $display("mid-run reset done");
    test_done();
  end
endmodule : flash_host_tb_top
bind flash_host flash_host_asserts u_chk (.clk_i, .nrst_i, .rd_i, .rdata_o, .ce_n_o, .oe_n_o, .we_n_o,
  .reset_n_o, .byte_n_o, .addr_o, .dq_oe_o);
